// ---- hdl/soc_pkg.sv ----
// Package for the system option register bank: addresses, bit positions, timing counts
package soc_pkg;
  // Register addresses in the device memory space
  localparam logic [15:0] SOC_ADDR_ONCE  = 16'h001d;
  localparam logic [15:0] SOC_ADDR_MULTI = 16'h001f;
  localparam logic [7:0]  SOC_RESET_VAL  = 8'h00;
  // First register bit positions
  localparam int SOC_B_WD_DISABLE   = 0;
  localparam int SOC_B_STOP_ENABLE  = 1;
  localparam int SOC_B_SHORT_REC    = 2;
  localparam int SOC_B_DET_PWR_DIS  = 4;
  localparam int SOC_B_DET_RST_DIS  = 5;
  localparam int SOC_B_DET_STOP_EN  = 6;
  localparam int SOC_B_WD_RATE_SEL  = 7;
  localparam int SOC_B_DET_REG_DIS  = 3;
  // Second register bit positions
  localparam int SOC_B_USB_RST_IRQ  = 0;
  localparam int SOC_B_USB_REG_DIS  = 1;
  localparam int SOC_B_RC_KEEP      = 2;
  localparam int SOC_B_XTAL_KEEP    = 3;
  // Timing in reference / crystal clock cycles
  localparam logic [17:0] SOC_WD_SHORT_CYC  = 18'd8176;
  localparam logic [17:0] SOC_WD_LONG_CYC   = 18'd262128;
  localparam logic [12:0] SOC_REC_SHORT_CYC = 13'd32;
  localparam logic [12:0] SOC_REC_LONG_CYC  = 13'd4096;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } soc_bus_type;

  typedef struct packed {
    logic        watchdog_enable;
    logic [17:0] watchdog_timeout;
    logic        detector_power_on;
    logic        detector_reset_enable;
    logic        detector_in_stop;
    logic        stop_legal;
    logic [12:0] stop_recovery;
    logic        oscillator_enable_signal;
    logic        rc_clock_enable;
    logic        usb_regulator_enable;
    logic        usb_reset_chip;
    logic        usb_reset_irq;
  } soc_opts_type;
endpackage : soc_pkg

// ---- hdl/soc_regs.sv ----
// System option register bank with write-once and multi-write registers
`timescale 1ns/10ps
//
// Contract
// R01: First register takes one write per reset; second takes any number.
// R02: All bits of both registers clear on reset.
// R03: Both registers read their contents at any time.
// R04: Registers live at addresses 001d and 001f.
// R05: Watchdog rate bit picks 8176 when one, 262128 when zero.
// R06: Stop detector enable works when power-disable or regulator-disable is clear.
// R07: Detector reset-disable bit blocks detector resets when one.
// R08: Detector power-disable bit powers detector and trip off when one.
// R09: Short-recovery bit picks 32 crystal cycles, else 4096.
// R10: Stop exit by reset always uses the long recovery delay.
// R11: Software should not set short recovery with an external crystal.
// R12: Stop-enable bit zero makes the STOP instruction illegal.
// R13: Watchdog disable bit one disables the watchdog module.
// R14: Crystal keep bit holds oscillator enable high in stop.
// R15: RC keep bit keeps RC clock running in stop.
// R16: USB regulator disable bit one turns the regulator off.
// R17: USB reset to irq bit picks interrupt instead of chip reset.
// R18: Software should program both registers right after reset.
// R19: Later writes to the first register are ignored until reset.
module soc_regs
  import soc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         nrst_in,
  // Register port
  input  wire soc_bus_type  bus_in,
  output logic [7:0]        rdata_out,
  // Device state
  input  wire logic         stop_mode_in,
  input  wire logic         stop_exit_by_reset_in,
  input  wire logic         usb_bus_reset_in,
  // Option outputs
  output soc_opts_type      opts_out,
  output logic              once_locked_out
);

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0]   system_options_once;
  logic [7:0]   system_options_multi;
  logic         once_written;
  soc_opts_type next_opts;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction : hit

  wire logic wr_once  = bus_in.wr && hit(bus_in.addr, SOC_ADDR_ONCE);  // R04
  wire logic wr_multi = bus_in.wr && hit(bus_in.addr, SOC_ADDR_MULTI); // R04

  //////////////////////////////////////////////////////////////////////////////
  // Write-once register; later writes silently dropped
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      system_options_once <= SOC_RESET_VAL; // R02
      once_written        <= 1'b0;
    end else if (wr_once && !once_written) begin // R01 R19
      system_options_once <= bus_in.wdata;
      once_written        <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      system_options_multi <= SOC_RESET_VAL; // R02
    end else if (wr_multi) begin
      system_options_multi <= bus_in.wdata; // R01
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd && hit(bus_in.addr, SOC_ADDR_ONCE)) begin
      rdata_out <= system_options_once; // R03
    end else if (bus_in.rd && hit(bus_in.addr, SOC_ADDR_MULTI)) begin
      rdata_out <= system_options_multi; // R03
    end else begin
      rdata_out <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Option decode; computed from next register values so outputs stay flopped
  logic [7:0] n1;
  logic [7:0] n2;
  always_comb begin
    n1 = (wr_once && !once_written) ? bus_in.wdata : system_options_once;
    n2 = wr_multi ? bus_in.wdata : system_options_multi;
    next_opts.watchdog_enable  = !n1[SOC_B_WD_DISABLE]; // R13
    next_opts.watchdog_timeout = n1[SOC_B_WD_RATE_SEL] ? SOC_WD_SHORT_CYC
                                                        : SOC_WD_LONG_CYC; // R05
    next_opts.detector_power_on     = !n1[SOC_B_DET_PWR_DIS]; // R08
    next_opts.detector_reset_enable = !n1[SOC_B_DET_RST_DIS]; // R07
    // Needs at least one of the two disables clear to run through stop
    next_opts.detector_in_stop = n1[SOC_B_DET_STOP_EN] &&
      (!n1[SOC_B_DET_PWR_DIS] || !n1[SOC_B_DET_REG_DIS]); // R06
    next_opts.stop_legal = n1[SOC_B_STOP_ENABLE]; // R12
    // Short recovery gives the detector less settle time than it needs
    next_opts.stop_recovery = (n1[SOC_B_SHORT_REC] && !stop_exit_by_reset_in)
                              ? SOC_REC_SHORT_CYC : SOC_REC_LONG_CYC; // R09 R10
    next_opts.oscillator_enable_signal = !stop_mode_in || n2[SOC_B_XTAL_KEEP]; // R14
    next_opts.rc_clock_enable          = !stop_mode_in || n2[SOC_B_RC_KEEP]; // R15
    next_opts.usb_regulator_enable     = !n2[SOC_B_USB_REG_DIS]; // R16
    next_opts.usb_reset_chip = usb_bus_reset_in && !n2[SOC_B_USB_RST_IRQ]; // R17
    next_opts.usb_reset_irq  = usb_bus_reset_in && n2[SOC_B_USB_RST_IRQ]; // R17
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      opts_out <= '{watchdog_enable: 1'b1, watchdog_timeout: SOC_WD_LONG_CYC,
                    detector_power_on: 1'b1, detector_reset_enable: 1'b1,
                    detector_in_stop: 1'b0, stop_legal: 1'b0,
                    stop_recovery: SOC_REC_LONG_CYC,
                    oscillator_enable_signal: 1'b1, rc_clock_enable: 1'b1,
                    usb_regulator_enable: 1'b1, usb_reset_chip: 1'b0,
                    usb_reset_irq: 1'b0};
      once_locked_out <= 1'b0;
    end else begin
      opts_out        <= next_opts;
      once_locked_out <= once_written || wr_once;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  chk_once_lock_holds: assert property ( // R19
    once_written && wr_once |=> $stable(system_options_once))
    else $error("first register changed after lock");
  chk_once_first_write: assert property ( // R01
    !once_written && wr_once |=> system_options_once == $past(bus_in.wdata) && once_written)
    else $error("first write not taken");
  chk_multi_write: assert property ( // R01
    wr_multi |=> system_options_multi == $past(bus_in.wdata))
    else $error("second register write lost");
  chk_read_once: assert property ( // R03
    bus_in.rd && bus_in.addr == SOC_ADDR_ONCE |=> rdata_out == $past(system_options_once))
    else $error("first register read wrong");
  chk_read_multi: assert property ( // R03
    bus_in.rd && bus_in.addr == SOC_ADDR_MULTI |=> rdata_out == $past(system_options_multi))
    else $error("second register read wrong");
  // Options and register load on the same edge, so compare against the current value
  chk_wd_timeout: assert property ( // R05
    ##1 opts_out.watchdog_timeout ==
      (system_options_once[SOC_B_WD_RATE_SEL] ? SOC_WD_SHORT_CYC : SOC_WD_LONG_CYC))
    else $error("watchdog timeout mismatch");
  chk_reset_recovery: assert property ( // R10
    stop_exit_by_reset_in |=> opts_out.stop_recovery == SOC_REC_LONG_CYC)
    else $error("reset exit used short recovery");
  chk_usb_route: assert property ( // R17
    !(opts_out.usb_reset_chip && opts_out.usb_reset_irq))
    else $error("usb reset routed both ways");
  chk_wd_enable: assert property ( // R13
    ##1 opts_out.watchdog_enable == !system_options_once[SOC_B_WD_DISABLE])
    else $error("watchdog enable mismatch");
  chk_once_clear_unlocked: assert property ( // R02
    !once_written |-> system_options_once == SOC_RESET_VAL)
    else $error("first register not clear before its write");
  chk_lock_flag: assert property ( // R19
    once_written |-> once_locked_out)
    else $error("lock flag low after first write");
  chk_read_idle: assert property ( // R03
    !bus_in.rd |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  chk_read_unmapped: assert property ( // R04
    bus_in.rd && !hit(bus_in.addr, SOC_ADDR_ONCE) && !hit(bus_in.addr, SOC_ADDR_MULTI)
      |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_det_power: assert property ( // R08
    opts_out.detector_power_on == !system_options_once[SOC_B_DET_PWR_DIS])
    else $error("detector power mismatch");
  chk_det_reset: assert property ( // R07
    opts_out.detector_reset_enable == !system_options_once[SOC_B_DET_RST_DIS])
    else $error("detector reset enable mismatch");
  chk_det_stop: assert property ( // R06
    opts_out.detector_in_stop == (system_options_once[SOC_B_DET_STOP_EN] &&
      !(system_options_once[SOC_B_DET_PWR_DIS] && system_options_once[SOC_B_DET_REG_DIS])))
    else $error("detector stop enable mismatch");
  chk_stop_legal: assert property ( // R12
    opts_out.stop_legal == system_options_once[SOC_B_STOP_ENABLE])
    else $error("stop legality mismatch");
  // Device-state inputs reach the options one edge later, hence the past value
  chk_short_recovery: assert property ( // R09
    ##1 opts_out.stop_recovery == ((system_options_once[SOC_B_SHORT_REC] &&
      !$past(stop_exit_by_reset_in)) ? SOC_REC_SHORT_CYC : SOC_REC_LONG_CYC))
    else $error("stop recovery mismatch");
  chk_osc_in_stop: assert property ( // R14
    ##1 opts_out.oscillator_enable_signal ==
      (!$past(stop_mode_in) || system_options_multi[SOC_B_XTAL_KEEP]))
    else $error("oscillator enable mismatch");
  chk_rc_in_stop: assert property ( // R15
    ##1 opts_out.rc_clock_enable ==
      (!$past(stop_mode_in) || system_options_multi[SOC_B_RC_KEEP]))
    else $error("rc clock enable mismatch");
  chk_usb_regulator: assert property ( // R16
    opts_out.usb_regulator_enable == !system_options_multi[SOC_B_USB_REG_DIS])
    else $error("usb regulator enable mismatch");
  chk_usb_chip_reset: assert property ( // R17
    ##1 opts_out.usb_reset_chip ==
      ($past(usb_bus_reset_in) && !system_options_multi[SOC_B_USB_RST_IRQ]))
    else $error("usb chip reset mismatch");
  chk_usb_irq: assert property ( // R17
    ##1 opts_out.usb_reset_irq ==
      ($past(usb_bus_reset_in) && system_options_multi[SOC_B_USB_RST_IRQ]))
    else $error("usb interrupt mismatch");

  cov_once_lock:   cover property (wr_once ##1 wr_once);
  cov_multi_twice: cover property (wr_multi ##[1:4] wr_multi);
  cov_read_after:  cover property (wr_once ##1 bus_in.rd);
  cov_reset_exit:  cover property (stop_exit_by_reset_in && system_options_once[SOC_B_SHORT_REC]);
  cov_usb_irq:     cover property (opts_out.usb_reset_irq);
endmodule : soc_regs

// ---- testbench/tb_soc_regs.sv ----
// Self-checking bench for the system option register bank
`timescale 1ns/10ps
module tb_soc_regs import soc_pkg::*;;
  logic         clk_sys_in = 1'b0;
  logic         nrst_in    = 1'b0;
  soc_bus_type  bus        = '0;
  logic         stop       = 1'b0;
  logic         xr         = 1'b0;
  logic         usb        = 1'b0;
  logic [7:0]   rdata_out;
  soc_opts_type opts_out;
  logic         lock;
  int           fail_count = 0;
  int           n_tests    = 0;
  int           cyc        = 0;
  logic [7:0]   tab [6]    = '{8'h00, 8'hff, 8'h48, 8'h58, 8'h84, 8'h26};
  always #4 clk_sys_in = ~clk_sys_in;
  soc_regs i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .bus_in(bus),
    .rdata_out(rdata_out), .stop_mode_in(stop), .stop_exit_by_reset_in(xr),
    .usb_bus_reset_in(usb), .opts_out(opts_out), .once_locked_out(lock));
  ////////////////////////////////////////////////////////////////////////////////
  // Expected option outputs from both register values and the device state
  function automatic soc_opts_type eo(input logic [7:0] o, input logic [7:0] m);
    eo = '0;
    eo.watchdog_enable = ~o[0];
    eo.watchdog_timeout = o[7] ? 18'd8176 : 18'd262128;
    eo.detector_power_on = ~o[4];
    eo.detector_reset_enable = ~o[5];
    eo.detector_in_stop = o[6] & ~(o[4] & o[3]);
    eo.stop_legal = o[1];
    eo.stop_recovery = (o[2] & ~xr) ? 13'd32 : 13'd4096;
    eo.oscillator_enable_signal = ~stop | m[3];
    eo.rc_clock_enable = ~stop | m[2];
    eo.usb_regulator_enable = ~m[1];
    eo.usb_reset_chip = usb & ~m[0];
    eo.usb_reset_irq = usb & m[0];
  endfunction : eo
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_opts(input soc_opts_type got, input soc_opts_type exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_opts
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk_sys_in);
    bus.wr    <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_sys_in);
    bus.rd   <= 1'b0;
    #1 cmp_byte(rdata_out, exp);
  endtask : rd_chk
  task automatic chk_opts(input logic [7:0] o, input logic [7:0] m);
    repeat (2) @(posedge clk_sys_in);
    #1 cmp_opts(opts_out, eo(o, m));
  endtask : chk_opts
  task automatic do_reset();
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    repeat (16) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(SOC_ADDR_ONCE, 8'h00);
    rd_chk(SOC_ADDR_MULTI, 8'h00);
    chk_opts(8'h00, 8'h00);
    cmp_byte({7'h0, lock}, 8'h00);
  endtask : t_reset
  // Each value needs its own reset, since the first register locks after one write
  task automatic t_once();
    foreach (tab[i]) begin
      do_reset();
      wr(SOC_ADDR_ONCE, tab[i]);
      wr(SOC_ADDR_ONCE, ~tab[i]);
      wr(16'h001e, 8'h5a);
      rd_chk(SOC_ADDR_ONCE, tab[i]);
      rd_chk(16'h001e, 8'h00);
      rd_chk(SOC_ADDR_MULTI, 8'h00);
      cmp_byte({7'h0, lock}, 8'h01);
      chk_opts(tab[i], 8'h00);
    end
  endtask : t_once
  task automatic t_multi();
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      @(posedge clk_sys_in);
      stop <= k[0];
      xr   <= k[1];
      usb  <= k[2];
      wr(SOC_ADDR_MULTI, {4'h0, k});
      rd_chk(SOC_ADDR_MULTI, {4'h0, k});
      chk_opts(tab[5], {4'h0, k});
    end
  endtask : t_multi
  task automatic results();
    if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    do_reset();
    t_reset();
    t_once();
    t_multi();
    results();
  end
endmodule : tb_soc_regs
